// ==== rtw_consts.svh ====
// timing and layout constants for the reduced two-wire channel
`ifndef RTW_CONSTS_SVH
`define RTW_CONSTS_SVH
`define RTW_PH_FIRST 2'h0
`define RTW_PH_RISE 2'h1
`define RTW_PH_SAMPLE 2'h2
`define RTW_PH_LAST 2'h3
`define RTW_BIT_FIRST 4'h0
`define RTW_ACK_SLOT 4'h8
`define RTW_BYTE_RST 8'h00
`define RTW_CNT_EMPTY 2'h0
`define RTW_CNT_FULL 2'h2
`define RTW_CNT_ONE 2'h1
`endif

// ==== rtw_pkg.sv ====
// types for the reduced two-wire channel
package rtw_pkg;
  typedef enum logic [2:0] {
    RTW_OP_START = 3'h0,
    RTW_OP_ADDR = 3'h1,
    RTW_OP_DATA = 3'h2,
    RTW_OP_RECV = 3'h3,
    RTW_OP_STOP = 3'h4
  } rtw_op_t;

  typedef struct packed {
    rtw_op_t op;
    logic [7:0] data;
  } rtw_cmd_t;

  typedef struct packed {
    rtw_op_t op;
    logic [7:0] data;
    logic ack_en;
  } rtw_req_t;

  typedef enum logic [1:0] {
    RTW_L_IDLE = 2'h0,
    RTW_L_START = 2'h1,
    RTW_L_BIT = 2'h2,
    RTW_L_STOP = 2'h3
  } rtw_lstate_t;
endpackage : rtw_pkg

// ==== rtw_channel.sv ====
// reduced two-wire single-master channel with link-clock serial engine
`include "rtw_consts.svh"

// Notes on behaviour
// - master only, single master; no slave transmit or receive path.
// - no arbitration loss check and no clock stretching detection.
// - each byte frame is eight data bits plus one acknowledge slot.
// - start and stop happen only when software requests them.
// - acknowledge sampled after each sent byte; missing one sets error.
// - reception drives acknowledge unless output enable cleared for byte.
// - this is the sole channel offering the reduced two-wire function.
// - operations: start, address send, data send, data receive, stop.
module rtw_channel (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic link_clk_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire rtw_pkg::rtw_cmd_t cmd_i,
  input wire logic chan2_serial_output_enable_i,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  output logic xfer_end_o,
  output logic ack_err_o,
  output logic ovr_err_o,
  input wire logic err_clr_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  function automatic logic is_byte_op(input rtw_pkg::rtw_op_t op);
    is_byte_op = (op == rtw_pkg::RTW_OP_ADDR) ||
                 (op == rtw_pkg::RTW_OP_DATA) ||
                 (op == rtw_pkg::RTW_OP_RECV);
  endfunction : is_byte_op

  // system clock side
  rtw_pkg::rtw_req_t req_q, req_d;
  logic req_tgl_q, req_tgl_d;
  logic busy_q, busy_d;
  logic done_s1_q, done_s2_q, done_s3_q;
  logic xfer_end_q, xfer_end_d;
  logic ack_err_q, ack_err_d;
  logic ovr_err_q, ovr_err_d;
  logic [7:0] buf_q [2];
  logic [7:0] buf_d [2];
  logic wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [1:0] cnt_q, cnt_d;

  // link clock side
  rtw_pkg::rtw_lstate_t lst_q, lst_d;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic sda_s1_q, sda_s2_q;
  logic [1:0] ph_q, ph_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic ack_q, ack_d;
  logic scl_low_q, scl_low_d;
  logic sda_low_q, sda_low_d;
  logic done_tgl_q, done_tgl_d;

  logic done_evt, push, pop, sending;

  assign done_evt = done_s2_q ^ done_s3_q;
  assign pop = rx_valid_o && rx_ready_i;
  assign push = done_evt && (req_q.op == rtw_pkg::RTW_OP_RECV);
  assign cmd_ready_o = !busy_q && (cnt_q != `RTW_CNT_FULL);
  assign rx_valid_o = (cnt_q != `RTW_CNT_EMPTY);
  assign rx_data_o = buf_q[rd_ptr_q];
  assign xfer_end_o = xfer_end_q;
  assign ack_err_o = ack_err_q;
  assign ovr_err_o = ovr_err_q;
  // open drain: drive low only
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_low_q;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_q;

  always_comb begin
    req_d = req_q;
    req_tgl_d = req_tgl_q;
    busy_d = busy_q;
    xfer_end_d = 1'b0;
    ack_err_d = ack_err_q;
    ovr_err_d = ovr_err_q;
    buf_d = buf_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    cnt_d = cnt_q;
    if (err_clr_i) begin
      ack_err_d = 1'b0;
      ovr_err_d = 1'b0;
    end
    if (cmd_valid_i && cmd_ready_o) begin
      req_d.op = cmd_i.op;
      req_d.data = cmd_i.data;
      req_d.ack_en = chan2_serial_output_enable_i;
      req_tgl_d = !req_tgl_q;
      busy_d = 1'b1;
    end
    if (done_evt) begin
      busy_d = 1'b0;
      xfer_end_d = is_byte_op(req_q.op);
      if ((req_q.op != rtw_pkg::RTW_OP_RECV) && is_byte_op(req_q.op) &&
          ack_q) begin
        ack_err_d = 1'b1;
      end
    end
    if (push) begin
      buf_d[wr_ptr_q] = sh_q;
      wr_ptr_d = !wr_ptr_q;
      if ((cnt_q != `RTW_CNT_EMPTY) && !pop) begin
        ovr_err_d = 1'b1;
      end
    end
    if (pop) begin
      rd_ptr_d = !rd_ptr_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + `RTW_CNT_ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - `RTW_CNT_ONE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_q <= '0;
      req_tgl_q <= 1'b0;
      busy_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      xfer_end_q <= 1'b0;
      ack_err_q <= 1'b0;
      ovr_err_q <= 1'b0;
      buf_q[0] <= `RTW_BYTE_RST;
      buf_q[1] <= `RTW_BYTE_RST;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= `RTW_CNT_EMPTY;
    end else begin
      req_q <= req_d;
      req_tgl_q <= req_tgl_d;
      busy_q <= busy_d;
      done_s1_q <= done_tgl_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      xfer_end_q <= xfer_end_d;
      ack_err_q <= ack_err_d;
      ovr_err_q <= ovr_err_d;
      buf_q <= buf_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      cnt_q <= cnt_d;
    end
  end

  // serial engine, four link clocks per bit; clock line never read
  assign sending = (req_q.op != rtw_pkg::RTW_OP_RECV);

  always_comb begin
    lst_d = lst_q;
    ph_d = ph_q + 2'h1;
    bit_d = bit_q;
    sh_d = sh_q;
    ack_d = ack_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    done_tgl_d = done_tgl_q;
    case (lst_q)
      rtw_pkg::RTW_L_IDLE: begin
        ph_d = `RTW_PH_FIRST;
        if (req_s2_q ^ req_s3_q) begin
          bit_d = `RTW_BIT_FIRST;
          sh_d = req_q.data;
          case (req_q.op)
            rtw_pkg::RTW_OP_START: lst_d = rtw_pkg::RTW_L_START;
            rtw_pkg::RTW_OP_STOP: lst_d = rtw_pkg::RTW_L_STOP;
            default: lst_d = rtw_pkg::RTW_L_BIT;
          endcase
        end
      end
      rtw_pkg::RTW_L_START: begin
        case (ph_q)
          `RTW_PH_FIRST: sda_low_d = 1'b0;
          `RTW_PH_RISE: scl_low_d = 1'b0;
          `RTW_PH_SAMPLE: sda_low_d = 1'b1;
          default: begin
            scl_low_d = 1'b1;
            done_tgl_d = !done_tgl_q;
            lst_d = rtw_pkg::RTW_L_IDLE;
          end
        endcase
      end
      rtw_pkg::RTW_L_STOP: begin
        case (ph_q)
          `RTW_PH_FIRST: sda_low_d = 1'b1;
          `RTW_PH_RISE: scl_low_d = 1'b0;
          `RTW_PH_SAMPLE: sda_low_d = 1'b0;
          default: begin
            done_tgl_d = !done_tgl_q;
            lst_d = rtw_pkg::RTW_L_IDLE;
          end
        endcase
      end
      rtw_pkg::RTW_L_BIT: begin
        case (ph_q)
          `RTW_PH_FIRST: begin
            scl_low_d = 1'b1;
            if (bit_q != `RTW_ACK_SLOT) begin
              sda_low_d = sending && !sh_q[7];
            end else begin
              sda_low_d = !sending && req_q.ack_en;
            end
          end
          `RTW_PH_RISE: scl_low_d = 1'b0;
          // synced line level still lags the change made in first phase
          `RTW_PH_SAMPLE: scl_low_d = 1'b0;
          default: begin
            scl_low_d = 1'b1;
            if (bit_q == `RTW_ACK_SLOT) begin
              ack_d = sda_s2_q;
              sda_low_d = 1'b0;
              done_tgl_d = !done_tgl_q;
              lst_d = rtw_pkg::RTW_L_IDLE;
            end else begin
              sh_d = {sh_q[6:0], sda_s2_q};
              bit_d = bit_q + 4'h1;
            end
          end
        endcase
      end
      default: lst_d = rtw_pkg::RTW_L_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lst_q <= rtw_pkg::RTW_L_IDLE;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      ph_q <= `RTW_PH_FIRST;
      bit_q <= `RTW_BIT_FIRST;
      sh_q <= `RTW_BYTE_RST;
      ack_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end else begin
      lst_q <= lst_d;
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      ph_q <= ph_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ack_q <= ack_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      done_tgl_q <= done_tgl_d;
    end
  end

endmodule : rtw_channel

// ==== rtw_asserts.sv ====
// assertion checker bound to the reduced two-wire channel
module rtw_asserts (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic link_clk_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire rtw_pkg::rtw_cmd_t cmd_i,
  input wire logic chan2_serial_output_enable_i,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] rx_data_o,
  input wire logic xfer_end_o,
  input wire logic ack_err_o,
  input wire logic ovr_err_o,
  input wire logic err_clr_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  property p_pins;
    cmd_ready_o |=> $stable(scl_oe_o) && $stable(sda_oe_o);
  endproperty
  a_pins: assert property (p_pins) else $error("line moved idle");
  property p_take; cmd_valid_i && cmd_ready_o |=> !cmd_ready_o; endproperty
  a_take: assert property (p_take) else $error("busy missing");
  property p_xe; xfer_end_o |=> !xfer_end_o; endproperty
  a_xe: assert property (p_xe) else $error("end pulse long");
  property p_xb; xfer_end_o |-> !$past(cmd_ready_o); endproperty
  a_xb: assert property (p_xb) else $error("end while idle");
  property p_ak; ack_err_o && !err_clr_i |=> ack_err_o; endproperty
  a_ak: assert property (p_ak) else $error("ack error lost");
  property p_ar; $rose(ack_err_o) |-> xfer_end_o; endproperty
  a_ar: assert property (p_ar) else $error("ack error early");
  property p_ov; ovr_err_o && !err_clr_i |=> ovr_err_o; endproperty
  a_ov: assert property (p_ov) else $error("overrun lost");
  property p_or; $rose(ovr_err_o) |-> xfer_end_o && rx_valid_o; endproperty
  a_or: assert property (p_or) else $error("overrun early");
  property p_cl;
    err_clr_i |=> xfer_end_o || (!ack_err_o && !ovr_err_o);
  endproperty
  a_cl: assert property (p_cl) else $error("errors not cleared");
  property p_hd;
    rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o);
  endproperty
  a_hd: assert property (p_hd) else $error("held byte lost");
  c_xe: cover property (xfer_end_o);
  c_ak: cover property ($rose(ack_err_o));
  c_ov: cover property ($rose(ovr_err_o));
endmodule : rtw_asserts
bind rtw_channel rtw_asserts rtw_asserts_i (.*);

// ==== rtw_slave.sv ====
// behavioural single slave on the two-wire bus
module rtw_slave (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  input wire logic [7:0] tx_i,
  output logic sda_oe_o,
  output logic ack_seen_o,
  output logic [7:0] byte_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_n = 0;
  logic rd = 0;
  logic first = 0;
  logic [7:0] sh = 8'h00;
  initial sda_oe_o = 0;
  initial ack_seen_o = 0;
  initial byte_o = 8'h00;
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    bit_n = -1;
    first = 1;
    rd = 0;
    sda_oe_o = 0;
  end
  always @(posedge scl_i) begin
    if (bit_n >= 0 && bit_n < 8) sh = {sh[6:0], sda_i};
    if (bit_n == 8) ack_seen_o = !sda_i;
  end
  always @(negedge scl_i) begin
    bit_n++;
    if (bit_n == 9) begin
      bit_n = 0;
      byte_o = sh;
      // direction from bit 0 of the address byte
      if (first) rd = sh[0];
      else if (!ack_seen_o) rd = 0;
      first = 0;
    end
    sda_oe_o = bit_n == 8 ? !rd && !nack_i : rd && !tx_i[7 - bit_n];
  end
endmodule : rtw_slave

// ==== rtw_tb.sv ====
// self-checking bench for the reduced two-wire channel
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 0, lclk = 0, rst_b = 1, cv = 0, oen = 1, rrdy = 0;
  logic clr = 0, nack = 0, s_oe, crdy, rv, xe, aerr, oerr, scl_oe, sda_oe;
  logic ack_seen;
  logic [7:0] rd, slv_b, tx, d;
  logic [6:0] a;
  rtw_pkg::rtw_cmd_t cmd = '0;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | s_oe);
  int error_cnt = 0, checked = 0;
  always #5 mclk_i = ~mclk_i;
  initial begin #3.3; forever #80 lclk = ~lclk; end
  rtw_channel rtw_channel_i (.mclk_i(mclk_i), .rst_b_i(rst_b),
    .link_clk_i(lclk), .cmd_valid_i(cv), .cmd_ready_o(crdy), .cmd_i(cmd),
    .chan2_serial_output_enable_i(oen), .rx_valid_o(rv), .rx_ready_i(rrdy),
    .rx_data_o(rd), .xfer_end_o(xe), .ack_err_o(aerr), .ovr_err_o(oerr),
    .err_clr_i(clr), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe));
  rtw_slave rtw_slave_i (.scl_i(scl), .sda_i(sda), .nack_i(nack),
    .tx_i(tx), .sda_oe_o(s_oe), .ack_seen_o(ack_seen), .byte_o(slv_b));
  function automatic logic [7:0] adr(logic [6:0] x, logic rw);
    return {x, rw};
  endfunction : adr
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic op(rtw_pkg::rtw_op_t o, logic [7:0] x, logic en);
    int n;
    logic byte_op;
    n = 0;
    byte_op = o inside {rtw_pkg::RTW_OP_ADDR, rtw_pkg::RTW_OP_DATA,
                        rtw_pkg::RTW_OP_RECV};
    cmd = {o, x};
    oen = en;
    cv = 1;
    while (crdy !== 1'b1 && n < 3000) begin @(posedge mclk_i); #1; n++; end
    @(posedge mclk_i);
    #1;
    cv = 0;
    do begin @(posedge mclk_i); #1; n++; end
    while (crdy !== 1'b1 && xe !== 1'b1 && n < 3000);
    chk("op_done", 8'h00, {7'h00, n >= 3000});
    chk("xfer_end", {7'h00, byte_op}, {7'h00, xe});
  endtask : op
  task automatic pop(logic [7:0] e);
    chk("rx_valid", 8'h01, {7'h00, rv});
    chk("rx_data", e, rd);
    rrdy = 1;
    @(posedge mclk_i);
    #1;
    rrdy = 0;
    @(posedge mclk_i);
    #1;
  endtask : pop
  task automatic close_out;
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial begin #400us; error_cnt++; close_out; end
  initial begin
    void'($urandom(32'h2E4C));
    tx = $urandom;
    a = $urandom;
    #1 rst_b = 0;
    repeat (3) @(posedge mclk_i);
    #1 rst_b = 1;
    repeat (3) @(posedge lclk);
    @(posedge mclk_i);
    #1;
    op(rtw_pkg::RTW_OP_START, 8'h00, 1);
    op(rtw_pkg::RTW_OP_ADDR, adr(a, 1'b0), 1);
    chk("addr", adr(a, 1'b0), slv_b);
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 8'h80 : $urandom;
      op(rtw_pkg::RTW_OP_DATA, d, 1);
      chk("wr_byte", d, slv_b);
      chk("ack_err", 8'h00, {7'h00, aerr});
    end
    nack = 1;
    op(rtw_pkg::RTW_OP_DATA, 8'h5A, 1);
    chk("nack_err", 8'h01, {7'h00, aerr});
    nack = 0;
    clr = 1;
    @(posedge mclk_i);
    #1 clr = 0;
    chk("err_clr", 8'h00, {7'h00, aerr});
    op(rtw_pkg::RTW_OP_START, 8'h00, 1);
    op(rtw_pkg::RTW_OP_ADDR, adr(a, 1'b1), 1);
    op(rtw_pkg::RTW_OP_RECV, 8'h00, 1);
    chk("ack_out", 8'h01, {7'h00, ack_seen});
    op(rtw_pkg::RTW_OP_RECV, 8'h00, 1);
    chk("ovr_err", 8'h01, {7'h00, oerr});
    chk("full_rdy", 8'h00, {7'h00, crdy});
    pop(tx);
    pop(tx);
    op(rtw_pkg::RTW_OP_RECV, 8'h00, 0);
    chk("no_ack", 8'h00, {7'h00, ack_seen});
    pop(tx);
    clr = 1;
    @(posedge mclk_i);
    #1 clr = 0;
    chk("ovr_clr", 8'h00, {7'h00, oerr});
    op(rtw_pkg::RTW_OP_STOP, 8'h00, 1);
    chk("stop_sda", 8'h01, {7'h00, sda});
    close_out;
  end
endmodule : tb
